//--- inc/cpu_regs_consts.svh
/*
 Constants of the core register set: widths, bus offsets, flag bit
 positions and reset values. Assumes byte addressing on the register bus.
*/
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH

`define WORD_W 16
`define WIDE_W 20
`define FLAG_W 11
`define PAIR_W 32
`define BUS_AW 6
`define BUS_DW 32
`define BUS_BE 4

`define OFS_ADDR0 6'h00
`define OFS_ADDR1 6'h04
`define OFS_FRAME 6'h08
`define OFS_STATIC 6'h0C
`define OFS_VECTOR 6'h10
`define OFS_IPTR 6'h14
`define OFS_USTACK 6'h18
`define OFS_ISTACK 6'h1C
`define OFS_FLAGS 6'h20
`define OFS_PAIR 6'h24

`define FLG_CARRY 0
`define FLG_DEBUG 1
`define FLG_ZERO 2
`define FLG_SIGN 3
`define FLG_BANK 4
`define FLG_OVFL 5
`define FLG_IE 6
`define FLG_STACK 7

`define RST_WORD 16'h0000
`define RST_WIDE 20'h00000
`define RST_FLAGS 11'h000
`define RST_BUS 32'h0000_0000

`endif

//--- inc/cpu_regs_pkg.sv
/*
 Types of the core register set: register selectors and the structs that
 carry core-side requests and the register view. Assumes the constants header.
*/
`include "cpu_regs_consts.svh"

package cpu_regs_pkg;

   typedef enum logic [3:0] {
      SEL_NONE, SEL_ADDR0, SEL_ADDR1, SEL_PAIR, SEL_FRAME,
      SEL_STATIC, SEL_VECTOR, SEL_STACK, SEL_FLAGS
   } reg_sel_e;

   typedef struct packed {
      reg_sel_e sel;
      logic [`PAIR_W-1:0] data;
   } core_write_s;

   typedef struct packed {
      logic valid;
      logic updCarry;
      logic updZeroSign;
      logic updOvfl;
      logic carry;
      logic ovfl;
      logic [`WORD_W-1:0] result;
   } alu_result_s;

   typedef struct packed {
      logic valid;
      logic [`WIDE_W-1:0] target;
   } pc_load_s;

   typedef struct packed {
      logic [`WORD_W-1:0] addr0;
      logic [`WORD_W-1:0] addr1;
      logic [`PAIR_W-1:0] addrPair;
      logic [`WORD_W-1:0] frameBase;
      logic [`WORD_W-1:0] staticBase;
      logic [`WIDE_W-1:0] vectorBase;
      logic [`WIDE_W-1:0] instrPtr;
      logic [`WORD_W-1:0] stackPtr;
      logic [`FLAG_W-1:0] flags;
   } core_view_s;

endpackage

//--- verilog/cpu_core_register_set.sv
/*
 Programmer-visible register set of a 16-bit core, with an Avalon-MM slave
 for software access and a same-clock port for the execution logic.
 Assumes core-side inputs are synchronous to clk_sys; resetn may be async.
*/
// Our own choices: the register offsets and register access over Avalon-MM.
// How it works
// RULE1 - Two 16-bit address registers, core operands
// RULE2 - Address registers join into 32-bit pair
// RULE3 - 16-bit frame base register
// RULE4 - 20-bit interrupt vector table base
// RULE5 - 20-bit program counter, next instruction
// RULE6 - User and interrupt stack, flag selects
// RULE7 - 16-bit static base register
// RULE8 - 11-bit flag register of status
// RULE9 - Carry flag captures ALU carry/borrow/shift
// RULE10 - Software keeps debug flag at zero
// RULE11 - Zero flag set on zero result
// RULE12 - Sign flag set on negative result
// RULE13 - Bank flag picks register bank 0/1
// RULE14 - Overflow flag follows operation overflow
// RULE15 - Interrupt enable flag gates maskable interrupts
// RULE16 - Accepting interrupt clears interrupt enable
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_consts.svh"

module cpu_core_register_set
   import cpu_regs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [`BUS_AW-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [`BUS_DW-1:0] writedata,
   input wire logic [`BUS_BE-1:0] byteenable,
   output logic [`BUS_DW-1:0] readdata,
   output logic waitrequest,
   input wire alu_result_s aluIn,
   input wire core_write_s coreWrite,
   input wire pc_load_s pcLoad,
   input wire logic irqRequest,
   output logic irqAccept,
   output core_view_s view
);

   function automatic logic [`BUS_DW-1:0] mergeBytes(
      input logic [`BUS_DW-1:0] old,
      input logic [`BUS_DW-1:0] data,
      input logic [`BUS_BE-1:0] be
   );
      logic [`BUS_DW-1:0] res;
      res = old;
      for (int i = 0; i < `BUS_BE; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Reset release through two stages
   logic [1:0] rstSync;
   logic rstN;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rstSync <= 2'b00;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstN = rstSync[1];

   // State
   logic [`WORD_W-1:0] a0Bank [2];
   logic [`WORD_W-1:0] a1Bank [2];
   logic [`WORD_W-1:0] fbBank [2];
   logic [`WORD_W-1:0] staticBase;
   logic [`WIDE_W-1:0] vectorBase;
   logic [`WIDE_W-1:0] instrPtr;
   logic [`WORD_W-1:0] userSp;
   logic [`WORD_W-1:0] intSp;
   logic [`FLAG_W-1:0] flags;

   logic [`WORD_W-1:0] next_a0Bank [2];
   logic [`WORD_W-1:0] next_a1Bank [2];
   logic [`WORD_W-1:0] next_fbBank [2];
   logic [`WORD_W-1:0] next_staticBase;
   logic [`WIDE_W-1:0] next_vectorBase;
   logic [`WIDE_W-1:0] next_instrPtr;
   logic [`WORD_W-1:0] next_userSp;
   logic [`WORD_W-1:0] next_intSp;
   logic [`FLAG_W-1:0] next_flags;
   logic next_irqAccept;
   core_view_s next_view;

   logic [`BUS_DW-1:0] next_readdata;
   logic next_waitrequest;
   logic [`BUS_DW-1:0] readValue;
   logic [`BUS_AW-1:0] regOfs;
   logic busWrite;
   logic bank;
   logic flagBusWrite;

   assign regOfs = {address[`BUS_AW-1:2], 2'b00};
   // A write lands only at the edge where waitrequest is seen low
   assign busWrite = write && !waitrequest;
   assign bank = flags[`FLG_BANK];
   // Such a write may move bank or stack under a core write
   assign flagBusWrite = busWrite && (regOfs == `OFS_FLAGS);

   // Read mux; unmapped offsets read zero, bits above width read zero
   always_comb begin
      case (regOfs)
         `OFS_ADDR0: readValue = 32'(a0Bank[bank]);
         `OFS_ADDR1: readValue = 32'(a1Bank[bank]);
         `OFS_FRAME: readValue = 32'(fbBank[bank]);
         `OFS_STATIC: readValue = 32'(staticBase);
         `OFS_VECTOR: readValue = 32'(vectorBase);
         `OFS_IPTR: readValue = 32'(instrPtr);
         `OFS_USTACK: readValue = 32'(userSp);
         `OFS_ISTACK: readValue = 32'(intSp);
         `OFS_FLAGS: readValue = 32'(flags);
         `OFS_PAIR: readValue = {a1Bank[bank], a0Bank[bank]};
         default: readValue = `RST_BUS;
      endcase
   end

   // Bus handshake: one wait cycle, then answer
   always_comb begin
      next_waitrequest = 1'b1;
      next_readdata = readdata;
      if ((read || write) && waitrequest) begin
         next_waitrequest = 1'b0;
         if (read) begin
            next_readdata = readValue;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         waitrequest <= 1'b1;
         readdata <= `RST_BUS;
      end else begin
         waitrequest <= next_waitrequest;
         readdata <= next_readdata;
      end
   end

   // Register updates: bus first, then core, then ALU flags, then interrupt
   always_comb begin
      logic [`BUS_DW-1:0] busMerged;
      logic [`WORD_W-1:0] spWord;
      // Read mux already zero-extends each register, so one merge serves all
      busMerged = mergeBytes(readValue, writedata, byteenable);
      spWord = coreWrite.data[`WORD_W-1:0];
      next_a0Bank = a0Bank;
      next_a1Bank = a1Bank;
      next_fbBank = fbBank;
      next_staticBase = staticBase;
      next_vectorBase = vectorBase;
      next_instrPtr = instrPtr;
      next_userSp = userSp;
      next_intSp = intSp;
      next_flags = flags;
      next_irqAccept = 1'b0;

      if (busWrite) begin
         case (regOfs)
            `OFS_ADDR0: next_a0Bank[bank] = busMerged[`WORD_W-1:0]; // [RULE1]
            `OFS_ADDR1: next_a1Bank[bank] = busMerged[`WORD_W-1:0]; // [RULE1]
            `OFS_FRAME: next_fbBank[bank] = busMerged[`WORD_W-1:0]; // [RULE3]
            `OFS_STATIC: next_staticBase = busMerged[`WORD_W-1:0]; // [RULE7]
            `OFS_VECTOR: next_vectorBase = busMerged[`WIDE_W-1:0]; // [RULE4]
            `OFS_IPTR: next_instrPtr = busMerged[`WIDE_W-1:0]; // [RULE5]
            `OFS_USTACK: next_userSp = busMerged[`WORD_W-1:0]; // [RULE6]
            `OFS_ISTACK: next_intSp = busMerged[`WORD_W-1:0]; // [RULE6]
            `OFS_FLAGS: next_flags = busMerged[`FLAG_W-1:0]; // [RULE8]
            `OFS_PAIR: begin
               next_a0Bank[bank] = busMerged[`WORD_W-1:0]; // [RULE2]
               next_a1Bank[bank] = busMerged[`PAIR_W-1:`WORD_W];
            end
            default: begin
            end
         endcase
      end

      // Core-side write wins over a bus write in the same cycle
      unique case (coreWrite.sel)
         SEL_NONE: begin
         end
         SEL_ADDR0: next_a0Bank[bank] = spWord; // [RULE1]
         SEL_ADDR1: next_a1Bank[bank] = spWord; // [RULE1]
         SEL_PAIR: begin
            next_a0Bank[bank] = coreWrite.data[`WORD_W-1:0]; // [RULE2]
            next_a1Bank[bank] = coreWrite.data[`PAIR_W-1:`WORD_W];
         end
         SEL_FRAME: next_fbBank[bank] = spWord; // [RULE3]
         SEL_STATIC: next_staticBase = spWord; // [RULE7]
         SEL_VECTOR: next_vectorBase = coreWrite.data[`WIDE_W-1:0]; // [RULE4]
         SEL_STACK: begin
            if (flags[`FLG_STACK]) begin
               next_userSp = spWord; // [RULE6]
            end else begin
               next_intSp = spWord; // [RULE6]
            end
         end
         SEL_FLAGS: next_flags = coreWrite.data[`FLAG_W-1:0]; // [RULE8]
         default: begin
         end
      endcase

      if (pcLoad.valid) begin
         next_instrPtr = pcLoad.target; // [RULE5]
      end

      // Hardware flag events beat any software write of the same cycle
      if (aluIn.valid) begin
         if (aluIn.updCarry) begin
            next_flags[`FLG_CARRY] = aluIn.carry; // [RULE9]
         end
         if (aluIn.updZeroSign) begin
            next_flags[`FLG_ZERO] = (aluIn.result == `RST_WORD); // [RULE11]
            next_flags[`FLG_SIGN] = aluIn.result[`WORD_W-1]; // [RULE12]
         end
         if (aluIn.updOvfl) begin
            next_flags[`FLG_OVFL] = aluIn.ovfl; // [RULE14]
         end
      end

      // Maskable request taken only while enabled
      if (irqRequest && flags[`FLG_IE]) begin // [RULE15]
         next_irqAccept = 1'b1;
         next_flags[`FLG_IE] = 1'b0; // [RULE16]
      end
   end

   // Registered view, built from next values so it tracks the state
   always_comb begin
      logic nb;
      nb = next_flags[`FLG_BANK];
      next_view.addr0 = next_a0Bank[nb]; // [RULE13]
      next_view.addr1 = next_a1Bank[nb];
      next_view.addrPair = {next_a1Bank[nb], next_a0Bank[nb]}; // [RULE2]
      next_view.frameBase = next_fbBank[nb];
      next_view.staticBase = next_staticBase;
      next_view.vectorBase = next_vectorBase;
      next_view.instrPtr = next_instrPtr;
      next_view.stackPtr = next_flags[`FLG_STACK] ? next_userSp : next_intSp; // [RULE6]
      next_view.flags = next_flags;
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         a0Bank <= '{`RST_WORD, `RST_WORD};
         a1Bank <= '{`RST_WORD, `RST_WORD};
         fbBank <= '{`RST_WORD, `RST_WORD};
         staticBase <= `RST_WORD;
         vectorBase <= `RST_WIDE;
         instrPtr <= `RST_WIDE;
         userSp <= `RST_WORD;
         intSp <= `RST_WORD;
         flags <= `RST_FLAGS;
         irqAccept <= 1'b0;
         view <= '0;
      end else begin
         a0Bank <= next_a0Bank;
         a1Bank <= next_a1Bank;
         fbBank <= next_fbBank;
         staticBase <= next_staticBase;
         vectorBase <= next_vectorBase;
         instrPtr <= next_instrPtr;
         userSp <= next_userSp;
         intSp <= next_intSp;
         flags <= next_flags;
         irqAccept <= next_irqAccept;
         view <= next_view;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstN);

   sequence busAsk;
      (read || write) && waitrequest;
   endsequence

   sequence busGive;
      !waitrequest ##1 waitrequest;
   endsequence

   a_bus_answer: assert property (busAsk |=> busGive)
      else $error("bus answer not one cycle after request");

   a_irq_mask_block: assert property (irqRequest && !flags[`FLG_IE] |=> !irqAccept) // [RULE15]
      else $error("interrupt taken while disabled");

   a_irq_clear_ie: assert property (irqAccept |-> !flags[`FLG_IE] && $past(flags[`FLG_IE])) // [RULE16]
      else $error("enable flag not cleared on accept");

   a_carry_capture: assert property (aluIn.valid && aluIn.updCarry |=> // [RULE9]
      flags[`FLG_CARRY] == $past(aluIn.carry))
      else $error("carry flag not captured");

   a_zero_flag: assert property (aluIn.valid && aluIn.updZeroSign |=> // [RULE11]
      flags[`FLG_ZERO] == ($past(aluIn.result) == `RST_WORD))
      else $error("zero flag wrong");

   a_sign_flag: assert property (aluIn.valid && aluIn.updZeroSign |=> // [RULE12]
      flags[`FLG_SIGN] == $past(aluIn.result[`WORD_W-1]))
      else $error("sign flag wrong");

   a_ovfl_flag: assert property (aluIn.valid && aluIn.updOvfl |=> // [RULE14]
      flags[`FLG_OVFL] == $past(aluIn.ovfl))
      else $error("overflow flag wrong");

   a_pc_load: assert property (pcLoad.valid |=> view.instrPtr == $past(pcLoad.target)) // [RULE5]
      else $error("program counter load lost");

   a_stack_select: assert property (view.stackPtr == (flags[`FLG_STACK] ? userSp : intSp)) // [RULE6]
      else $error("wrong stack pointer in view");

   a_bank_select: assert property (view.addr0 == a0Bank[flags[`FLG_BANK]] && // [RULE13]
      view.frameBase == fbBank[flags[`FLG_BANK]])
      else $error("bank selection wrong");

   a_pair_join: assert property (view.addrPair == {view.addr1, view.addr0}) // [RULE2]
      else $error("address pair mismatch");

   sequence flagsRead;
      read && waitrequest && (regOfs == `OFS_FLAGS);
   endsequence

   sequence vectorRead;
      read && waitrequest && (regOfs == `OFS_VECTOR);
   endsequence

   // Bits above the register width must read zero, not stale data
   a_read_flags: assert property (flagsRead |=> readdata == 32'($past(flags))) // [RULE8]
      else $error("flag register read wrong");

   a_read_vector: assert property (vectorRead |=> readdata == 32'($past(vectorBase))) // [RULE4]
      else $error("vector base read wrong");

   a_bus_idle: assert property (!read && !write |=> waitrequest)
      else $error("waitrequest low without request");

   a_irq_take: assert property (irqRequest && flags[`FLG_IE] |=> irqAccept && !flags[`FLG_IE]) // [RULE15]
      else $error("enabled interrupt not taken");

   a_bank_addr1: assert property (view.addr1 == a1Bank[flags[`FLG_BANK]]) // [RULE13]
      else $error("bank selection wrong for second address");

   // Banked targets are only checked when the bank cannot move under them
   a_core_pair: assert property (coreWrite.sel == SEL_PAIR && !flagBusWrite |=> // [RULE2]
      view.addrPair == $past(coreWrite.data))
      else $error("core pair write lost");

   a_stack_write: assert property (coreWrite.sel == SEL_STACK && !flagBusWrite |=> // [RULE6]
      view.stackPtr == $past(coreWrite.data[`WORD_W-1:0]))
      else $error("core stack write lost");

   a_frame_write: assert property (coreWrite.sel == SEL_FRAME && !flagBusWrite |=> // [RULE3]
      view.frameBase == $past(coreWrite.data[`WORD_W-1:0]))
      else $error("core frame base write lost");

   a_static_write: assert property (coreWrite.sel == SEL_STATIC |=> // [RULE7]
      view.staticBase == $past(coreWrite.data[`WORD_W-1:0]))
      else $error("core static base write lost");

   a_vector_write: assert property (coreWrite.sel == SEL_VECTOR |=> // [RULE4]
      view.vectorBase == $past(coreWrite.data[`WIDE_W-1:0]))
      else $error("core vector base write lost");

   a_addr0_write: assert property (coreWrite.sel == SEL_ADDR0 && !flagBusWrite |=> // [RULE1]
      view.addr0 == $past(coreWrite.data[`WORD_W-1:0]))
      else $error("core address write lost");

endmodule
`default_nettype wire

//--- sim/core_exec_model.sv
/*
 Model of the execution and interrupt logic that drives the core port.
 Assumes it shares clk_sys with the register set; tasks are called between edges
 and all but irq return 1 ns after the edge that applies the strobe, so views are settled.
*/
`timescale 1ns/100ps
`default_nettype none
module core_exec_model
   import cpu_regs_pkg::*;
(
   input wire logic clk_sys,
   output var alu_result_s aluIn,
   output var core_write_s coreWrite,
   output var pc_load_s pcLoad,
   output var logic irqRequest
);
   initial begin
      aluIn = '0;
      coreWrite = '0;
      pcLoad = '0;
      irqRequest = 1'b0;
   end
   // Idle data is inverted so a design that ignores valid shows up
   task automatic alu(input logic [15:0] res, input logic c, input logic o);
      @(posedge clk_sys);
      aluIn <= '{1'b1, 1'b1, 1'b1, 1'b1, c, o, res};
      @(posedge clk_sys);
      aluIn <= '{1'b0, 1'b0, 1'b0, 1'b0, ~c, ~o, ~res};
      #1;
   endtask
   // Callers keep the debug bit clear in any flags value
   task automatic cwrite(input reg_sel_e sel, input logic [31:0] d);
      @(posedge clk_sys);
      coreWrite <= '{sel, d};
      @(posedge clk_sys);
      coreWrite <= '{SEL_NONE, ~d};
      #1;
   endtask
   task automatic pc(input logic [19:0] t);
      @(posedge clk_sys);
      pcLoad <= '{1'b1, t};
      @(posedge clk_sys);
      pcLoad <= '{1'b0, ~t};
      #1;
   endtask
   task automatic irq(input logic lvl);
      @(posedge clk_sys);
      irqRequest <= lvl;
   endtask
endmodule
`default_nettype wire

//--- sim/test_cpu_core_register_set.sv
/*
 Self-checking bench of the core register set: bus table, then hand tests.
 Assumes the core-port model in core_exec_model and a 50 MHz clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regs_consts.svh"
module test_cpu_core_register_set import cpu_regs_pkg::*;;
   typedef struct packed {logic [5:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] e;} row_s;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] readdata;
   logic waitrequest;
   alu_result_s aluIn;
   core_write_s coreWrite;
   pc_load_s pcLoad;
   logic irqRequest;
   logic irqAccept;
   core_view_s view;
   logic [31:0] rd;
   int nMismatch = 0;
   int nChecks = 0;
   // Write, then read back; debug bit kept clear in every flags value
   const row_s rows[13] = '{
      '{6'h00, 32'h1234ABCD, 4'hF, 32'h0000ABCD}, '{6'h04, 32'hFFFF5678, 4'hF, 32'h00005678},
      '{6'h00, 32'h0000EEEE, 4'h1, 32'h0000ABEE}, '{6'h24, 32'hFFFFFFFF, 4'h0, 32'h5678ABEE},
      '{6'h24, 32'h9ABC0123, 4'hC, 32'h9ABCABEE}, '{6'h08, 32'h0000FFFF, 4'hF, 32'h0000FFFF},
      '{6'h0C, 32'h12345555, 4'hF, 32'h00005555}, '{6'h10, 32'hFFFFFFFF, 4'hF, 32'h000FFFFF},
      '{6'h14, 32'hABCDE123, 4'hF, 32'h000DE123}, '{6'h18, 32'h00001111, 4'hF, 32'h00001111},
      '{6'h1C, 32'h00002222, 4'hF, 32'h00002222}, '{6'h20, 32'hFFFFF70D, 4'hF, 32'h0000070D},
      '{6'h3C, 32'hFFFFFFFF, 4'hF, 32'h00000000}};
   const logic [17:0] alus[3] = '{{16'h0000, 2'b11}, {16'h8000, 2'b00}, {16'h0001, 2'b10}};

   always #10 clk_sys = ~clk_sys;

   cpu_core_register_set i_dut (.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .aluIn(aluIn), .coreWrite(coreWrite), .pcLoad(pcLoad),
      .irqRequest(irqRequest), .irqAccept(irqAccept), .view(view));
   core_exec_model i_core (.clk_sys(clk_sys), .aluIn(aluIn), .coreWrite(coreWrite), .pcLoad(pcLoad),
      .irqRequest(irqRequest));

   task automatic chk(input string nm, input logic [191:0] exp, input logic [191:0] got);
      nChecks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         nMismatch++;
      end
   endtask
   task automatic testDone();
      if (nMismatch == 0 && nChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Request held until waitrequest is seen low; bounded so a dead slave ends the run
   task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      @(posedge clk_sys);
      n = 0;
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= we;
      read <= ~we;
      do begin
         @(posedge clk_sys);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 20) begin
         nMismatch++;
         testDone();
      end
   endtask
   task automatic flags(input logic [31:0] d);
      bus(1'b1, 6'h20, d, 4'hF);
      #1;
   endtask

   initial begin
      logic [31:0] ex;
      int cnt;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d, rows[i].be);
         bus(1'b0, rows[i].a, 32'h0, 4'h0);
         chk("readdata", rows[i].e, rd);
      end
      chk("vectorBase", 32'h000FFFFF, view.vectorBase);
      chk("stackPtr isp", 32'h2222, view.stackPtr);
      flags(32'h80);
      chk("stackPtr usp", 32'h1111, view.stackPtr);
      // Bank 1 was never written, so it still shows its reset value
      flags(32'h90);
      chk("addr0 bank1", 32'h0, view.addr0);
      bus(1'b1, 6'h00, 32'h7777, 4'hF);
      flags(32'h80);
      chk("addr0 bank0", 32'hABEE, view.addr0);
      flags(32'h90);
      chk("addr0 bank1", 32'h7777, view.addr0);
      flags(32'h80);
      foreach (alus[i]) begin
         i_core.alu(alus[i][17:2], alus[i][1], alus[i][0]);
         ex = 32'h80;
         ex[0] = alus[i][1];
         ex[2] = (alus[i][17:2] == 16'h0000);
         ex[3] = alus[i][17];
         ex[5] = alus[i][0];
         chk("flags alu", ex, view.flags);
      end
      i_core.cwrite(SEL_PAIR, 32'hCAFE1234);
      chk("addrPair", 32'hCAFE1234, view.addrPair);
      chk("addr1", 32'hCAFE, view.addr1);
      i_core.pc(20'h54321);
      chk("instrPtr", 32'h54321, view.instrPtr);
      i_core.cwrite(SEL_FLAGS, 32'h00000580);
      chk("flags core", 32'h580, view.flags);
      i_core.cwrite(SEL_STACK, 32'h0000BEEF);
      chk("stackPtr core", 32'hBEEF, view.stackPtr);
      bus(1'b0, 6'h1C, 32'h0, 4'h0);
      chk("isp kept", 32'h2222, rd);
      i_core.cwrite(SEL_FRAME, 32'h00004321);
      chk("frameBase", 32'h4321, view.frameBase);
      i_core.cwrite(SEL_STATIC, 32'h00008765);
      chk("staticBase", 32'h8765, view.staticBase);
      i_core.cwrite(SEL_VECTOR, 32'h000ABCDE);
      chk("vectorBase core", 32'hABCDE, view.vectorBase);
      i_core.cwrite(SEL_ADDR0, 32'h00005A5A);
      chk("addr0 core", 32'h5A5A, view.addr0);
      i_core.cwrite(SEL_ADDR1, 32'h0000A5A5);
      chk("addr1 core", 32'hA5A5, view.addr1);
      // Request held while masked must not be taken
      i_core.irq(1'b1);
      cnt = 0;
      repeat (4) begin
         @(posedge clk_sys);
         cnt += (irqAccept === 1'b1);
      end
      chk("irqAccept masked", 32'h0, cnt);
      flags(32'hC0);
      cnt = 0;
      repeat (6) begin
         @(posedge clk_sys);
         cnt += (irqAccept === 1'b1);
      end
      #1;
      chk("irqAccept count", 32'h1, cnt);
      chk("enable after accept", 32'h0, view.flags[6]);
      i_core.irq(1'b0);
      // Reset in mid-run clears both banks and the bus side
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("view in reset", 192'h0, view);
      chk("waitrequest in reset", 32'h1, waitrequest);
      chk("readdata in reset", 32'h0, readdata);
      // Release again: bank 1 held data before, so both banks must read clear
      @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      bus(1'b0, 6'h24, 32'h0, 4'h0);
      chk("pair after reset", 32'h0, rd);
      flags(32'h10);
      chk("addr0 bank1 after reset", 32'h0, view.addr0);
      testDone();
   end
endmodule
`default_nettype wire
